// file: bench/ddrc_core_bench.sv
// Purpose: self-checking bench for the dram controller core
// Assumes: apb master; dram clock from the device model
// Notes: init runs its full 250 ticks
`timescale 1ns/1ps
`default_nettype none
module ddrc_core_bench;
    logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, srefresh_req, irq, e;
    logic dram_cke, rate_select, dram_source_clock, dll_locked;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, rnd;
    logic [3:0] sys_ack, sys_err, st;
    logic [6:0] dqs_delay_0, dqs_delay_1;
    logic [1:0] dram_cs_n;
    ddrc_pkg::ddrc_req_t [3:0] sys_req;
    ddrc_pkg::ddrc_cmd_t dram_cmd;
    int mismatches, n_tests, n_sref, i;
    logic [11:0] ofs [5] = '{12'h020, 12'h048, 12'h06c, 12'h070, 12'h004};
    ddrc_core i_dut (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .sys_req, .sys_ack, .sys_err, .dram_source_clock, .srefresh_req,
        .dll_locked, .dram_cmd, .dram_cs_n, .dram_cke, .dram_addr(), .dram_ba(),
        .dram_we_data(), .rate_select, .dqs_delay_0, .dqs_delay_1, .irq);
    ddrc_mem_model i_mem (.dram_source_clock, .dll_locked, .dram_cmd, .n_sref);
    // ****
    // tasks
    // ****
    function automatic logic [31:0] xorshift(input logic [31:0] v);
        logic [31:0] s;
        s = v ^ (v << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xorshift
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
        n_tests++;
        if (s !== x)
        begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, x, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask : apb
    // i ends as the cycles waited for the port's answer
    task automatic req(input int p, input logic [31:0] a);
        sys_req[p] <= '{1'b1, 1'b0, a};
        i = 0;
        do @(posedge ref_clk); while (sys_ack[p] !== 1'b1 && i++ < 3000);
        chk("err", {31'h0, sys_err[p]}, {31'h0, a[27]});
        chk("ack", {31'h0, sys_ack[p]}, 1);
        chk("cmd", {29'h0, dram_cmd}, a[27] ? 32'(ddrc_pkg::CMD_NOP) : 32'(ddrc_pkg::CMD_ACT));
        chk("cs", {30'h0, dram_cs_n}, a[27] ? 32'h0 : (a[26] ? 32'h1 : 32'h2));
        sys_req[p] <= '0;
        @(posedge ref_clk);
    endtask : req
    task automatic tally_and_finish();
        if (mismatches == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    // ****
    // stimulus
    // ****
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial
    begin
        #3000000;
        mismatches++;
        tally_and_finish();
    end
    initial
    begin
        {mismatches, n_tests, rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
        sys_req = '0;
        srefresh_req = 1'b0;
        rnd = 32'h71eb706d;
        repeat (20) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        foreach (ofs[k])
        begin
            apb(1'b0, ofs[k], '0);
            chk("rd", q, '0);
            chk("slverr", {31'h0, e}, k == 4);
        end
        rnd = xorshift(rnd);
        apb(1'b1, 12'h048, rnd | 32'h1f);
        apb(1'b0, 12'h048, '0);
        chk("dly", q, rnd & 32'h7f7f001f | 32'h1f);
        chk("dly1", {25'h0, dqs_delay_1}, {25'h0, rnd[30:24]});
        apb(1'b1, 12'h020, 32'hff0000ff);
        apb(1'b0, 12'h020, '0);
        chk("mode", q, 32'h01000001);
        chk("rate", {31'h0, rate_select}, 1);
        apb(1'b1, 12'h020, 32'h00010000);
        chk("rate", {31'h0, rate_select}, 0);
        for (i = 0; i < 900 && q[10] !== 1'b1; i++)
            apb(1'b0, 12'h048, '0);
        st = 4'h4;
        chk("stat", {27'h0, q[12:8]}, {|st, st});
        chk("irq", {31'h0, irq}, 0);
        apb(1'b1, 12'h048, rnd & 32'h7f7f0000);
        @(posedge ref_clk);
        chk("irq", {31'h0, irq}, 1);
        for (int p = 0; p < 4; p++)
            req(p, (p < 2) ? 32'h08000000 : 32'h00000100);
        apb(1'b0, 12'h048, '0);
        st = 4'h7;
        chk("stat", {27'h0, q[12:8]}, {|st, st});
        apb(1'b1, 12'h080, 32'h3);
        apb(1'b0, 12'h048, '0);
        st = 4'h4;
        chk("stat", {27'h0, q[12:8]}, {|st, st});
        srefresh_req <= 1'b1;
        for (i = 0; i < 300 && dram_cke !== 1'b0; i++)
            @(posedge ref_clk);
        chk("cke", {31'h0, dram_cke}, 0);
        apb(1'b0, 12'h020, '0);
        chk("mode", q, 32'h00010100);
        chk("sref", n_sref, 1);
        srefresh_req <= 1'b0;
        apb(1'b1, 12'h020, 32'h00010000);
        req(3, 32'h00000200);
        chk("resume", i > 1500, 1);
        tally_and_finish();
    end
endmodule : ddrc_core_bench
`default_nettype wire

// file: bench/ddrc_mem_model.sv
// Purpose: stand-in for the external dram devices
// Assumes: dll stays locked
// Notes: dram clock runs free, unrelated to the bus clock
`timescale 1ns/1ps
`default_nettype none
module ddrc_mem_model (
    // toward controller
    output logic dram_source_clock,
    output logic dll_locked,
    // from controller
    input wire ddrc_pkg::ddrc_cmd_t dram_cmd,
    output int n_sref
);
    // ****
    // clock and self-refresh count
    // ****
    initial
    begin
        n_sref = 0;
        dll_locked = 1'b1;
        dram_source_clock = 1'b0;
        #37;
        forever #400 dram_source_clock = ~dram_source_clock;
    end
    always @(dram_cmd)
        if (dram_cmd == ddrc_pkg::CMD_SREF)
            n_sref++;
endmodule : ddrc_mem_model
`default_nettype wire

// file: design/ddrc_core.sv
// Purpose: dram controller core with apb registers and four request ports
// Assumes: dram clock is a pin sampled by ref_clk; ports hold valid until ack
// Notes: command timing advances on dram clock rising edges only
`timescale 1ns/1ps
`default_nettype none
module ddrc_core #(
    parameter int NUM_CS = 2
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // system bus ports
    input wire ddrc_pkg::ddrc_req_t [3:0] sys_req,
    output logic [3:0] sys_ack,
    output logic [3:0] sys_err,
    // pins from outside
    input wire logic dram_source_clock,
    input wire logic srefresh_req,
    input wire logic dll_locked,
    // memory side
    output var ddrc_pkg::ddrc_cmd_t dram_cmd,
    output logic [1:0] dram_cs_n,
    output logic dram_cke,
    output logic [12:0] dram_addr,
    output logic [1:0] dram_ba,
    output logic dram_we_data,
    output logic rate_select,
    output logic [6:0] dqs_delay_0,
    output logic [6:0] dqs_delay_1,
    // interrupt
    output logic irq
);
    // ****************************************
    // input synchronisers and edges
    // ****************************************
    logic [2:0] pin_s;
    logic clk_d_ff;
    logic sref_d_ff;
    logic dll_d_ff;
    logic tick;
    logic sref_rise;
    logic dll_fall;

    ddrc_sync #(.W(3)) u_sync (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .async_in({dll_locked, srefresh_req, dram_source_clock}),
        .sync_out(pin_s)
    );

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            clk_d_ff <= 1'b0;
            sref_d_ff <= 1'b0;
            dll_d_ff <= 1'b0;
        end
        else
        begin
            clk_d_ff <= pin_s[0];
            sref_d_ff <= pin_s[1];
            dll_d_ff <= pin_s[2];
        end
    end

    assign tick = pin_s[0] & ~clk_d_ff;
    assign sref_rise = pin_s[1] & ~sref_d_ff;
    assign dll_fall = dll_d_ff & ~pin_s[2];

    // ****************************************
    // apb decode
    // ****************************************
    logic pready_ff;
    logic pslverr_ff;
    logic [31:0] prdata_ff;
    logic acc;
    logic wr_done;
    logic sel_mode;
    logic sel_dly;
    logic sel_una;
    logic sel_unb;
    logic sel_ack;
    logic mapped;
    logic wr_mode;
    logic wr_dly;
    logic wr_ack;
    logic [31:0] rd_mode;
    logic [31:0] rd_dly;
    logic [31:0] rd_word;

    // answer comes one cycle into the access phase
    assign acc = psel & penable & ~pready_ff;
    assign wr_done = psel & penable & pwrite & pready_ff;
    assign sel_mode = (paddr == ddrc_pkg::OFS_MODE);
    assign sel_dly = (paddr == ddrc_pkg::OFS_DLY_IRQ);
    assign sel_una = (paddr == ddrc_pkg::OFS_UNUSED_A);
    assign sel_unb = (paddr == ddrc_pkg::OFS_UNUSED_B);
    assign sel_ack = (paddr == ddrc_pkg::OFS_INT_ACK);
    assign mapped = sel_mode | sel_dly | sel_una | sel_unb | sel_ack;
    assign wr_mode = wr_done & sel_mode;
    assign wr_dly = wr_done & sel_dly;
    assign wr_ack = wr_done & sel_ack;

    // ****************************************
    // control registers
    // ****************************************
    logic eap_ff;
    logic start_ff;
    logic sref_ff;
    logic rate_ff;
    logic [6:0] dly0_ff;
    logic [6:0] dly1_ff;
    logic [4:0] mask_ff;
    logic nxt_sref;

    // pin assertion wins over a register write in the same cycle
    assign nxt_sref = sref_rise ? 1'b1 : (wr_mode ? pwdata[ddrc_pkg::POS_SREF] : sref_ff);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            eap_ff <= 1'b0;
            start_ff <= 1'b0;
            rate_ff <= 1'b0;
            sref_ff <= 1'b0;
        end
        else
        begin
            sref_ff <= nxt_sref;
            if (wr_mode)
            begin
                eap_ff <= pwdata[ddrc_pkg::POS_EAP];
                start_ff <= pwdata[ddrc_pkg::POS_START];
                rate_ff <= pwdata[ddrc_pkg::POS_RATE];
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            dly0_ff <= 7'h00;
            dly1_ff <= 7'h00;
            mask_ff <= 5'h00;
        end
        else if (wr_dly)
        begin
            dly1_ff <= pwdata[ddrc_pkg::POS_DLY1 +: ddrc_pkg::DLY_W];
            dly0_ff <= pwdata[ddrc_pkg::POS_DLY0 +: ddrc_pkg::DLY_W];
            mask_ff <= pwdata[ddrc_pkg::POS_MASK +: ddrc_pkg::STAT_W];
        end
    end

    // ****************************************
    // status
    // ****************************************
    logic [1:0] oor_flags;
    logic init_ff;
    logic unlock_ff;
    logic init_set;
    logic [4:0] status;
    logic irq_ff;
    logic accept;
    logic oor;
    logic [1:0] sel_ff;
    logic [1:0] pick;
    logic any_req;

    ddrc_oor #(.NUM_CS(NUM_CS)) u_oor (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .chk(accept),
        .addr(sys_req[pick].addr),
        .oor(oor),
        .clr(wr_ack ? pwdata[1:0] : 2'h0),
        .flags(oor_flags)
    );

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            init_ff <= 1'b0;
            unlock_ff <= 1'b0;
        end
        else
        begin
            init_ff <= init_set | (init_ff & ~(wr_ack & pwdata[2]));
            unlock_ff <= (dll_fall & start_ff) | (unlock_ff & ~(wr_ack & pwdata[3]));
        end
    end

    assign status = {|{unlock_ff, init_ff, oor_flags}, unlock_ff, init_ff, oor_flags};

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            irq_ff <= 1'b0;
        else
            irq_ff <= |(status & ~mask_ff);
    end

    // ****************************************
    // read mux
    // ****************************************
    // reserved and obsolete fields are tied low here
    assign rd_mode = {7'h00, eap_ff, 7'h00, start_ff, 7'h00, sref_ff, 7'h00, rate_ff};
    assign rd_dly = {1'b0, dly1_ff, 1'b0, dly0_ff, 3'h0, status, 3'h0, mask_ff};
    assign rd_word = sel_mode ? rd_mode : (sel_dly ? rd_dly : ddrc_pkg::RST_WORD);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= ddrc_pkg::RST_WORD;
        end
        else
        begin
            pready_ff <= acc;
            pslverr_ff <= acc & ~mapped;
            prdata_ff <= acc ? rd_word : ddrc_pkg::RST_WORD;
        end
    end

    // ****************************************
    // port arbitration
    // ****************************************
    logic [1:0] rr_ff;
    logic [3:0] ack_ff;
    logic [3:0] err_ff;

    // rotating priority keeps any port from starving the others
    always_comb
    begin
        pick = rr_ff;
        any_req = 1'b0;
        for (int i = 3; i >= 0; i--)
        begin
            if (sys_req[2'(rr_ff + 2'(i))].valid)
            begin
                pick = 2'(rr_ff + 2'(i));
                any_req = 1'b1;
            end
        end
    end

    // ****************************************
    // command sequencer
    // ****************************************
    ddrc_pkg::ddrc_state_t state_ff;
    ddrc_pkg::ddrc_state_t nxt_state;
    ddrc_pkg::ddrc_cmd_t cmd_ff;
    ddrc_pkg::ddrc_cmd_t nxt_cmd;
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic [7:0] tras_ff;
    logic [7:0] nxt_tras;
    logic cke_ff;
    logic nxt_cke;
    logic [1:0] cs_n_ff;
    logic [1:0] nxt_cs_n;
    logic [1:0] cs_out_ff;
    logic [1:0] nxt_cs_out;
    logic [12:0] addr_ff;
    logic [12:0] nxt_addr;
    logic [1:0] ba_ff;
    logic [12:0] col_word;
    logic wr_ff;
    logic [7:0] burst;

    assign burst = rate_ff ? 8'(ddrc_pkg::BURST_SDR) : 8'(ddrc_pkg::BURST_DDR);
    assign col_word = {3'h0, sys_req[pick].addr[10:1]};
    assign nxt_cs_n = accept ? (sys_req[pick].addr[ddrc_pkg::CS_SPAN_BIT] ? 2'h1 : 2'h2) : cs_n_ff;
    // chip selects are registered so the pins never glitch on a state change
    assign nxt_cs_out = (nxt_state == ddrc_pkg::ST_INIT || nxt_state == ddrc_pkg::ST_IDLE ||
        nxt_state == ddrc_pkg::ST_SREF) ? 2'h0 : nxt_cs_n;

    always_comb
    begin
        nxt_state = state_ff;
        nxt_cmd = ddrc_pkg::CMD_NOP;
        nxt_cnt = cnt_ff;
        nxt_tras = (tras_ff != 8'h00) ? tras_ff - 8'h01 : tras_ff;
        nxt_cke = cke_ff;
        nxt_addr = addr_ff;
        init_set = 1'b0;
        accept = 1'b0;
        case (state_ff)
            ddrc_pkg::ST_OFF:
                if (start_ff)
                begin
                    nxt_state = ddrc_pkg::ST_INIT;
                    nxt_cnt = 8'(ddrc_pkg::INIT_TICKS);
                    nxt_cke = 1'b1;
                end
            ddrc_pkg::ST_INIT:
                if (cnt_ff == 8'h00)
                begin
                    nxt_cmd = ddrc_pkg::CMD_PRE;
                    nxt_addr = ddrc_pkg::ADDR_PRE_ALL;
                    nxt_state = ddrc_pkg::ST_IDLE;
                    init_set = tick;
                end
                else
                    nxt_cnt = cnt_ff - 8'h01;
            ddrc_pkg::ST_IDLE:
                if (!start_ff)
                begin
                    nxt_state = ddrc_pkg::ST_OFF;
                    nxt_cke = 1'b0;
                end
                else if (sref_ff)
                    nxt_state = ddrc_pkg::ST_SREN;
                else if (any_req && ack_ff == 4'h0)
                begin
                    accept = tick;
                    if (!oor)
                    begin
                        nxt_state = ddrc_pkg::ST_ACT;
                        nxt_cmd = ddrc_pkg::CMD_ACT;
                        nxt_addr = sys_req[pick].addr[25:13];
                        nxt_tras = 8'(ddrc_pkg::TRAS_TICKS);
                    end
                end
            ddrc_pkg::ST_ACT:
                if (eap_ff || tras_ff == 8'h00)
                begin
                    nxt_cmd = wr_ff ? ddrc_pkg::CMD_WR : ddrc_pkg::CMD_RD;
                    nxt_addr = col_word | ddrc_pkg::ADDR_PRE_ALL;
                    nxt_cnt = burst;
                    nxt_state = ddrc_pkg::ST_RW;
                end
            ddrc_pkg::ST_RW:
                if (cnt_ff <= 8'h01)
                    nxt_state = ddrc_pkg::ST_IDLE;
                else
                    nxt_cnt = cnt_ff - 8'h01;
            ddrc_pkg::ST_SREN:
            begin
                nxt_cmd = ddrc_pkg::CMD_SREF;
                nxt_cke = 1'b0;
                nxt_state = ddrc_pkg::ST_SREF;
            end
            ddrc_pkg::ST_SREF:
                if (!sref_ff)
                begin
                    nxt_cke = 1'b1;
                    nxt_cnt = 8'(ddrc_pkg::TXSR_TICKS + ddrc_pkg::DLL_TICKS);
                    nxt_state = ddrc_pkg::ST_SREX;
                end
            ddrc_pkg::ST_SREX:
                if (cnt_ff == 8'h00)
                    nxt_state = ddrc_pkg::ST_IDLE;
                else
                    nxt_cnt = cnt_ff - 8'h01;
            default:
                nxt_state = ddrc_pkg::ST_OFF;
        endcase
    end

    // sequencer state moves only on dram clock edges
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            state_ff <= ddrc_pkg::ST_OFF;
            cmd_ff <= ddrc_pkg::CMD_NOP;
            cnt_ff <= 8'h00;
            tras_ff <= 8'h00;
            cke_ff <= 1'b0;
            addr_ff <= 13'h0000;
            cs_out_ff <= 2'h3;
        end
        else if (tick)
        begin
            state_ff <= nxt_state;
            cmd_ff <= nxt_cmd;
            cnt_ff <= nxt_cnt;
            tras_ff <= nxt_tras;
            cke_ff <= nxt_cke;
            addr_ff <= nxt_addr;
            cs_out_ff <= nxt_cs_out;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            rr_ff <= 2'h0;
            ack_ff <= 4'h0;
            err_ff <= 4'h0;
            cs_n_ff <= 2'h3;
            ba_ff <= 2'h0;
            wr_ff <= 1'b0;
        end
        else
        begin
            ack_ff <= accept ? 4'h1 << pick : 4'h0;
            err_ff <= (accept && oor) ? 4'h1 << pick : 4'h0;
            if (accept)
            begin
                rr_ff <= 2'(pick + 2'h1);
                ba_ff <= sys_req[pick].addr[12:11];
                wr_ff <= sys_req[pick].write;
                cs_n_ff <= nxt_cs_n;
            end
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign sys_ack = ack_ff;
    assign sys_err = err_ff;
    assign dram_cmd = cmd_ff;
    assign dram_cs_n = cs_out_ff;
    assign dram_cke = cke_ff;
    assign dram_addr = addr_ff;
    assign dram_ba = ba_ff;
    assign dram_we_data = wr_ff;
    assign rate_select = rate_ff;
    assign dqs_delay_0 = dly0_ff;
    assign dqs_delay_1 = dly1_ff;
    assign irq = irq_ff;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence apb_rd_s;
        psel && penable && pready && !pwrite;
    endsequence

    sequence sref_exit_s;
        (state_ff == ddrc_pkg::ST_SREF) ##1 (state_ff == ddrc_pkg::ST_SREX);
    endsequence

    off_quiet_a: assert property (state_ff == ddrc_pkg::ST_OFF && !start_ff |-> dram_cmd == ddrc_pkg::CMD_NOP)
        else $error("command issued while inactive");
    start_init_a: assert property ($rose(start_ff) && state_ff == ddrc_pkg::ST_OFF |-> ##[1:24] state_ff == ddrc_pkg::ST_INIT)
        else $error("init did not start");
    init_flag_a: assert property (tick && state_ff == ddrc_pkg::ST_INIT && cnt_ff == 8'h00 |=> status[2])
        else $error("init complete not flagged");
    stat_or_a: assert property (apb_rd_s ##0 (paddr == ddrc_pkg::OFS_DLY_IRQ) |-> prdata[12] == |prdata[11:8])
        else $error("status top bit is not the or");
    mask_all_a: assert property (mask_ff == 5'h1f |=> !irq)
        else $error("masked interrupt raised");
    sref_pin_a: assert property (sref_rise |=> sref_ff)
        else $error("pin did not set self refresh");
    sref_cke_a: assert property (state_ff == ddrc_pkg::ST_SREF |-> !dram_cke)
        else $error("cke high in self refresh");
    sref_exit_a: assert property (sref_exit_s |-> dram_cke && cnt_ff != 8'h00)
        else $error("self refresh exit without wait");
    tras_hold_a: assert property (tick && !eap_ff && state_ff == ddrc_pkg::ST_ACT && tras_ff != 8'h00 |=> state_ff == ddrc_pkg::ST_ACT)
        else $error("auto precharge before row time");
    oor_flag_a: assert property (accept && oor |=> oor_flags[0] && $onehot(sys_err))
        else $error("out of range not flagged");
    ack_one_a: assert property ($onehot0(sys_ack) && (sys_ack == 4'h0 || $past(state_ff) == ddrc_pkg::ST_IDLE))
        else $error("bad port acknowledge");
endmodule : ddrc_core
`default_nettype wire

// file: design/ddrc_oor.sv
// Purpose: out-of-range decode and its two sticky status bits
// Assumes: 64MB per chip select
// Notes: a set in the same cycle as a clear wins
`timescale 1ns/1ps
`default_nettype none
module ddrc_oor #(
    parameter int NUM_CS = 2
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // check request
    input wire logic chk,
    input wire logic [31:0] addr,
    output logic oor,
    // status
    input wire logic [1:0] clr,
    output logic [1:0] flags
);
    logic [1:0] flags_ff;
    logic [1:0] nxt_flags;
    logic [5:0] cs_idx;
    logic hit;

    assign cs_idx = addr[31:ddrc_pkg::CS_SPAN_BIT];
    assign oor = (cs_idx >= 6'(NUM_CS));
    assign hit = chk & oor;
    // second violation while the first is still flagged counts as multiple
    assign nxt_flags[0] = hit | (flags_ff[0] & ~clr[0]);
    assign nxt_flags[1] = (hit & flags_ff[0]) | (flags_ff[1] & ~clr[1]);

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            flags_ff <= 2'h0;
        else
            flags_ff <= nxt_flags;
    end

    assign flags = flags_ff;
endmodule : ddrc_oor
`default_nettype wire

// file: design/ddrc_sync.sv
// Purpose: two-flop synchroniser for pins from outside the bus clock
// Assumes: inputs are slow levels
// Notes: only the second flop is read outside
`timescale 1ns/1ps
`default_nettype none
module ddrc_sync #(
    parameter int W = 3
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst_n,
    // levels
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] sync_ff;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            meta_ff <= '0;
            sync_ff <= '0;
        end
        else
        begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;
endmodule : ddrc_sync
`default_nettype wire

// file: pkg/ddrc_pkg.sv
// Purpose: shared constants and types for the ddr dram controller core
// Assumes: apb slave with 32-bit words; dram clock sampled as a plain input
// Notes: dram timing counts are in ticks of the sampled dram clock
// Behaviour
// - works with both mobile ddr and standard ddr1 memories
// - drives up to two chip-select outputs toward memory
// - decodes 128MB with two chip selects, 64MB with one
// - dram clock is asynchronous to the bus clock; crossings are synchronised
// - accepts memory requests from four system bus ports
// - early auto-precharge allowed when bit 24 set, else waits minimum row time
// - with activation bit 16 clear, no memory commands and no requests served; a running init or access still issues its PRE or RD/WR
// - setting activation bit 16 runs initialisation, then serves requests
// - self-refresh bit 8 set finishes burst, closes banks, enters, drops cke
// - writing bit 8 to zero exits after exit and dll time, then resumes
// - self-refresh pin assertion sets bit 8; software clears it to leave
// - rate select bit 0 picks ddr when 0, sdr when 1
// - read strobe delay per slice, fields 30:24 and 22:16, 1/128 steps
// - status 12:8 flags single, multiple out-of-range, init done, dll unlock
// - status bit 4 is the or of the four lower bits
// - out-of-range accesses raise single then multiple violation bits
// - interrupt is status and-ed with inverted mask 4:0
package ddrc_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [11:0] OFS_MODE = 12'h020;
    localparam logic [11:0] OFS_DLY_IRQ = 12'h048;
    localparam logic [11:0] OFS_UNUSED_A = 12'h06c;
    localparam logic [11:0] OFS_UNUSED_B = 12'h070;
    localparam logic [11:0] OFS_INT_ACK = 12'h080;
    localparam logic [31:0] RST_WORD = 32'h00000000;
    localparam int unsigned POS_EAP = 32'h18;
    localparam int unsigned POS_START = 32'h10;
    localparam int unsigned POS_SREF = 32'h08;
    localparam int unsigned POS_RATE = 32'h00;
    localparam int unsigned POS_DLY1 = 32'h18;
    localparam int unsigned POS_DLY0 = 32'h10;
    localparam int unsigned POS_STAT = 32'h08;
    localparam int unsigned POS_MASK = 32'h00;
    localparam int unsigned DLY_W = 32'h7;
    localparam int unsigned STAT_W = 32'h5;
    // ****************************************
    // memory layout
    // ****************************************
    localparam int unsigned NUM_PORTS = 32'h4;
    localparam int unsigned CS_SPAN_BIT = 32'h1a;
    localparam logic [12:0] ADDR_PRE_ALL = 13'h0400;
    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned DRAM_PERIOD_NS = 32'h320;
    localparam int unsigned TINIT_NS = 32'h30d40;
    localparam int unsigned TRAS_NS = 32'h2d;
    localparam int unsigned TXSR_NS = 32'h78;
    localparam int unsigned DLL_TICKS = 32'hc8;
    localparam int unsigned INIT_TICKS = (TINIT_NS + DRAM_PERIOD_NS - 1) / DRAM_PERIOD_NS;
    localparam int unsigned TRAS_TICKS = (TRAS_NS + DRAM_PERIOD_NS - 1) / DRAM_PERIOD_NS;
    localparam int unsigned TXSR_TICKS = (TXSR_NS + DRAM_PERIOD_NS - 1) / DRAM_PERIOD_NS;
    localparam int unsigned BURST_DDR = 32'h2;
    localparam int unsigned BURST_SDR = 32'h4;
    // ****************************************
    // types
    // ****************************************
    typedef struct packed {
        logic valid;
        logic write;
        logic [31:0] addr;
    } ddrc_req_t;
    typedef struct packed {
        logic ras_n;
        logic cas_n;
        logic we_n;
    } ddrc_cmd_t;
    localparam ddrc_cmd_t CMD_NOP = 3'h7;
    localparam ddrc_cmd_t CMD_ACT = 3'h3;
    localparam ddrc_cmd_t CMD_RD = 3'h5;
    localparam ddrc_cmd_t CMD_WR = 3'h4;
    localparam ddrc_cmd_t CMD_PRE = 3'h2;
    localparam ddrc_cmd_t CMD_SREF = 3'h1;
    typedef enum logic [7:0] {
        ST_OFF = 8'h01,
        ST_INIT = 8'h02,
        ST_IDLE = 8'h04,
        ST_ACT = 8'h08,
        ST_RW = 8'h10,
        ST_SREN = 8'h20,
        ST_SREF = 8'h40,
        ST_SREX = 8'h80
    } ddrc_state_t;
endpackage : ddrc_pkg
